// [src/flag_xfer_pkg.sv]
// Constants and types for the flag and data transfer executor
package flag_xfer_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_INSTR    = 8'h00;
   localparam logic [7:0] OFS_FLAGS    = 8'h04;
   localparam logic [7:0] OFS_STATE    = 8'h08;
   localparam logic [7:0] OFS_REG_SEL  = 8'h0C;
   localparam logic [7:0] OFS_REG_DATA = 8'h10;
   localparam logic [7:0] OFS_MEM_ADDR = 8'h14;
   localparam logic [7:0] OFS_MEM_DATA = 8'h18;

   // ==========================================================
   // Instruction word fields (lsb positions)
   localparam int F_OP = 0;
   localparam int F_D  = 6;
   localparam int F_R  = 11;
   localparam int F_B  = 16;
   localparam int F_K  = 19;
   localparam int F_P  = 27;

   // ==========================================================
   // Operation codes; 6'h20..6'h3F are the dedicated flag forms
   localparam logic [5:0] OP_SWAP   = 6'h00;
   localparam logic [5:0] OP_FRAISE  = 6'h01;
   localparam logic [5:0] OP_FDROP   = 6'h02;
   localparam logic [5:0] OP_B2T     = 6'h03;
   localparam logic [5:0] OP_T2B     = 6'h04;
   localparam logic [5:0] OP_COPY    = 6'h05;
   localparam logic [5:0] OP_PCOPY   = 6'h06;
   localparam logic [5:0] OP_IMM     = 6'h07;
   localparam logic [5:0] OP_PRD     = 6'h08;
   localparam logic [5:0] OP_PRD_INC = 6'h09;
   localparam logic [5:0] OP_PRD_DEC = 6'h0A;
   localparam logic [5:0] OP_ORD     = 6'h0B;
   localparam logic [5:0] OP_DRD     = 6'h0C;
   localparam logic [5:0] OP_PWR     = 6'h0D;
   localparam logic [5:0] OP_PWR_INC = 6'h0E;
   localparam logic [5:0] OP_PWR_DEC = 6'h0F;
   localparam logic [5:0] OP_OWR     = 6'h10;
   localparam logic [5:0] OP_RAISE  = 6'h20;
   localparam logic [5:0] OP_DROP   = 6'h28;

   // ==========================================================
   // Status flag positions
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;

   // ==========================================================
   // Pointer pairs: select codes and low register index
   localparam logic [1:0] PTR_X = 2'h0;
   localparam logic [1:0] PTR_Y = 2'h1;
   localparam logic [1:0] PTR_Z = 2'h2;
   localparam logic [4:0] X_LO  = 5'h1A;
   localparam logic [4:0] Y_LO  = 5'h1C;
   localparam logic [4:0] Z_LO  = 5'h1E;

   localparam int MEM_DEPTH = 256;

   typedef enum logic [1:0] {S_IDLE, S_EXEC, S_MEM} phase_e;

   typedef struct packed {
      phase_e           phase;
      logic [31:0]      instr;
      logic [31:0][7:0] rf;
      logic [7:0]       flags;
      logic [15:0]      addr;
      logic [4:0]       reg_sel;
      logic [7:0]       mem_addr;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
   } core_s;

   localparam core_s CORE_RST = '0;

endpackage

// [src/flag_and_data_transfer_exec.sv]
// Executor for bit, flag and data transfer instructions behind APB
`timescale 1ns/1ns

module flag_and_data_transfer_exec
   import flag_xfer_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   core_s      q_r;
   core_s      q_nxt;
   logic [7:0] mem [0:MEM_DEPTH-1];

   logic [5:0]  op;
   logic [4:0]  rd;
   logic [4:0]  rr;
   logic [2:0]  bsel;
   logic [7:0]  kv;
   logic [1:0]  psel_p;
   logic [4:0]  plo;
   logic [4:0]  phi;
   logic [15:0] ptr;
   logic        busy;
   logic        is_load;
   logic        is_inc;
   logic        setup;
   logic        acc;
   logic        mem_we;
   logic [7:0]  mem_wa;
   logic [7:0]  mem_wd;

   // ==========================================================
   // Instruction decode
   assign op     = q_r.instr[F_OP +: 6];
   assign rd     = q_r.instr[F_D +: 5];
   assign rr     = q_r.instr[F_R +: 5];
   assign bsel   = q_r.instr[F_B +: 3];
   assign kv     = q_r.instr[F_K +: 8];
   assign psel_p = q_r.instr[F_P +: 2];
   assign busy   = (q_r.phase != S_IDLE);
   assign is_load = (op == OP_PRD) || (op == OP_PRD_INC) ||
                    (op == OP_PRD_DEC) || (op == OP_ORD) ||
                    (op == OP_DRD);
   assign is_inc = (op == OP_PRD_INC) || (op == OP_PWR_INC);

   always_comb begin
      case (psel_p)
         PTR_Y:   plo = Y_LO;
         PTR_Z:   plo = Z_LO;
         default: plo = X_LO;
      endcase
   end

   assign phi = plo + 5'h01;
   assign ptr = {q_r.rf[phi], q_r.rf[plo]};

   // ==========================================================
   // APB phases; a transfer is answered in its first access cycle
   assign setup = psel & ~penable;
   assign acc   = psel & penable & q_r.pready;

   // ==========================================================
   // Next state
   always_comb begin
      q_nxt   = q_r;
      mem_we  = 1'b0;
      mem_wa  = q_r.mem_addr;
      mem_wd  = pwdata[7:0];
      q_nxt.pready  = setup;
      q_nxt.pslverr = 1'b0;

      // Read data and error answer prepared in the setup cycle
      if (setup) begin
         q_nxt.prdata = '0;
         unique case (paddr)
            OFS_INSTR:    q_nxt.prdata = q_r.instr;
            OFS_FLAGS:    q_nxt.prdata[7:0] = q_r.flags;
            OFS_STATE:    q_nxt.prdata[0] = busy;
            OFS_REG_SEL:  q_nxt.prdata[4:0] = q_r.reg_sel;
            OFS_REG_DATA: q_nxt.prdata[7:0] = q_r.rf[q_r.reg_sel];
            OFS_MEM_ADDR: q_nxt.prdata[7:0] = q_r.mem_addr;
            OFS_MEM_DATA: q_nxt.prdata[7:0] = mem[q_r.mem_addr];
            default:      q_nxt.pslverr = 1'b1;
         endcase
         // Writes that would race the executor are refused
         if (pwrite && (paddr == OFS_STATE ||
             (busy && paddr != OFS_REG_SEL &&
              paddr != OFS_MEM_ADDR)))
            q_nxt.pslverr = 1'b1;
      end

      if (acc && pwrite && !q_r.pslverr) begin
         case (paddr)
            OFS_INSTR: begin
               q_nxt.instr = pwdata;
               q_nxt.phase = S_EXEC;
            end
            OFS_FLAGS:    q_nxt.flags = pwdata[7:0];
            OFS_REG_SEL:  q_nxt.reg_sel = pwdata[4:0];
            OFS_REG_DATA: q_nxt.rf[q_r.reg_sel] = pwdata[7:0];
            OFS_MEM_ADDR: q_nxt.mem_addr = pwdata[7:0];
            OFS_MEM_DATA: mem_we = 1'b1;
            default: ;
         endcase
      end

      // Instruction execution
      unique case (q_r.phase)
         S_IDLE: ;
         S_EXEC: begin
            q_nxt.phase = S_IDLE;
            if (op[5]) begin
               q_nxt.flags[op[2:0]] = ~op[3];
            end else begin
               case (op)
                  OP_SWAP:
                     q_nxt.rf[rd] = {q_r.rf[rd][3:0],
                                     q_r.rf[rd][7:4]};
                  OP_FRAISE: q_nxt.flags[bsel] = 1'b1;
                  OP_FDROP: q_nxt.flags[bsel] = 1'b0;
                  OP_B2T:
                     q_nxt.flags[FLG_T] = q_r.rf[rr][bsel];
                  OP_T2B:
                     q_nxt.rf[rd][bsel] = q_r.flags[FLG_T];
                  OP_COPY: q_nxt.rf[rd] = q_r.rf[rr];
                  OP_PCOPY: begin
                     q_nxt.rf[{rd[4:1], 1'b0}] =
                        q_r.rf[{rr[4:1], 1'b0}];
                     q_nxt.rf[{rd[4:1], 1'b1}] =
                        q_r.rf[{rr[4:1], 1'b1}];
                  end
                  OP_IMM: q_nxt.rf[rd] = kv;
                  OP_PRD, OP_PRD_INC, OP_PWR, OP_PWR_INC: begin
                     q_nxt.addr  = ptr;
                     q_nxt.phase = S_MEM;
                  end
                  OP_PRD_DEC, OP_PWR_DEC: begin
                     q_nxt.addr  = ptr - 16'h0001;
                     {q_nxt.rf[phi], q_nxt.rf[plo]} =
                        ptr - 16'h0001;
                     q_nxt.phase = S_MEM;
                  end
                  OP_ORD, OP_OWR: begin
                     q_nxt.addr  = ptr + {10'h000, kv[5:0]};
                     q_nxt.phase = S_MEM;
                  end
                  OP_DRD: begin
                     q_nxt.addr  = {8'h00, kv};
                     q_nxt.phase = S_MEM;
                  end
                  default: ;
               endcase
            end
         end
         S_MEM: begin
            q_nxt.phase = S_IDLE;
            if (is_load) begin
               q_nxt.rf[rd] = mem[q_r.addr[7:0]];
            end else begin
               mem_we = 1'b1;
               mem_wa = q_r.addr[7:0];
               mem_wd = q_r.rf[rr];
            end
            if (is_inc)
               {q_nxt.rf[phi], q_nxt.rf[plo]} =
                  ptr + 16'h0001;
         end
      endcase
   end

   // ==========================================================
   // State and memory registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         q_r <= CORE_RST;
      else
         q_r <= q_nxt;
   end

   always_ff @(posedge pclk) begin
      if (mem_we)
         mem[mem_wa] <= mem_wd;
   end

   assign prdata  = q_r.prdata;
   assign pready  = q_r.pready;
   assign pslverr = q_r.pslverr;

   // ==========================================================
   // Assertions
   logic       ex;
   logic       src_bit;
   logic [7:0] fmask;
   logic [7:0] mem_at;

   assign ex      = (q_r.phase == S_EXEC);
   assign src_bit = q_r.rf[rr][bsel];
   assign fmask   = 8'h01 << (op[5] ? op[2:0] : bsel);
   assign mem_at  = mem[q_r.addr[7:0]];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_mem_idle;
      q_r.phase == S_MEM ##1 q_r.phase == S_IDLE;
   endsequence

   a_bit_to_t: assert property (
      ex && op == OP_B2T |=> q_r.flags[FLG_T] == $past(src_bit) &&
      ((q_r.flags ^ $past(q_r.flags)) & 8'hBF) == 8'h00 &&
      q_r.phase == S_IDLE)
      else $error("T flag copy wrong");

   a_t_to_bit: assert property (
      ex && op == OP_T2B |=> q_r.rf[$past(rd)][$past(bsel)] ==
      $past(q_r.flags[FLG_T]) && $stable(q_r.flags))
      else $error("bit load from T wrong");

   a_flag_one: assert property (
      ex && (op[5] || op == OP_FRAISE || op == OP_FDROP) |=>
      ((q_r.flags ^ $past(q_r.flags)) & ~$past(fmask)) == 8'h00 &&
      q_r.phase == S_IDLE)
      else $error("flag op touched another flag");

   a_ld_inc: assert property (
      ex && op == OP_PRD_INC |=> s_mem_idle and
      (1'b1 ##1 ptr == $past(ptr, 2) + 16'h0001))
      else $error("post-increment load wrong");

   a_ld_dec: assert property (
      ex && op == OP_PRD_DEC |=> ptr == $past(ptr) - 16'h0001 &&
      q_r.addr == ptr ##0 s_mem_idle)
      else $error("pre-decrement load wrong");

   a_ldd_keep: assert property (
      ex && op == OP_ORD |=> s_mem_idle and $stable(ptr)[*2])
      else $error("displacement load moved pointer");

   a_lds_data: assert property (
      q_r.phase == S_MEM && op == OP_DRD |=>
      q_r.rf[rd] == $past(mem_at) && $stable(q_r.flags))
      else $error("direct load data wrong");

   a_st_inc: assert property (
      ex && op == OP_PWR_INC |=> mem_we && mem_wa == $past(ptr[7:0])
      ##1 ptr == $past(ptr, 2) + 16'h0001)
      else $error("post-increment store wrong");

   a_st_dec: assert property (
      ex && op == OP_PWR_DEC |=> mem_we &&
      mem_wa == $past(ptr[7:0]) - 8'h01 && $stable(q_r.flags))
      else $error("pre-decrement store wrong");

   a_std_keep: assert property (
      ex && op == OP_OWR |=> mem_we && mem_wd == q_r.rf[rr] &&
      $stable(ptr) ##1 q_r.phase == S_IDLE)
      else $error("displacement store wrong");

   a_one_cycle: assert property (
      ex && (op == OP_SWAP || op == OP_COPY || op == OP_PCOPY ||
      op == OP_IMM) |=> q_r.phase == S_IDLE && $stable(q_r.flags))
      else $error("single-cycle transfer wrong");

   a_flag_hit: assert property (
      ex && op[5] |=> q_r.flags[$past(op[2:0])] == ~$past(op[3]))
      else $error("dedicated flag form missed its flag");

   a_idx_raise: assert property (
      ex && op == OP_FRAISE |=> q_r.flags[$past(bsel)])
      else $error("indexed flag raise missed");

   a_idx_drop: assert property (
      ex && op == OP_FDROP |=> !q_r.flags[$past(bsel)])
      else $error("indexed flag drop missed");

   a_imm_value: assert property (
      ex && op == OP_IMM |=> q_r.rf[$past(rd)] == $past(kv))
      else $error("immediate load value wrong");

   a_store_data: assert property (
      q_r.phase == S_MEM && !is_load |-> mem_we &&
      mem_wd == q_r.rf[rr] && mem_wa == q_r.addr[7:0])
      else $error("store write port wrong");

endmodule // flag_and_data_transfer_exec

// [dv/apb_host_model.sv]
// APB host model that issues single transfers to the executor
`timescale 1ns/1ns

module apb_host_model (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata,
   // APB answer
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
   end

   // ======================================================
   // Setup cycle, then access held until pready at an edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released data must not keep showing the last value
      pwdata  <= ~d;
   endtask
endmodule // apb_host_model

// [dv/tb_top.sv]
// Self-checking bench for the flag and data transfer executor
`timescale 1ns/1ns
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
   err_total++; $display("ERROR %s exp %0h got %0h", n, e, a); end end

module tb_top
   import flag_xfer_pkg::*;
;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rv;
   logic        er;
   int          err_total = 0;
   int          compares = 0;
   int          cyc = 0;

   flag_and_data_transfer_exec flag_and_data_transfer_exec_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   apb_host_model apb_host_model_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // ======================================================
   // Bus and access helpers
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      apb_host_model_inst.xfer(w, a, d, rv, er);
   endtask
   task automatic sr(input logic [4:0] i, input logic [7:0] v);
      bus(1'b1, OFS_REG_SEL, {27'h0, i});
      bus(1'b1, OFS_REG_DATA, {24'h0, v});
   endtask
   task automatic cr(input logic [4:0] i, input logic [7:0] v);
      bus(1'b1, OFS_REG_SEL, {27'h0, i});
      bus(1'b0, OFS_REG_DATA, 32'h0);
      `CHK("reg", {24'h0, v}, rv)
   endtask
   task automatic sm(input logic [7:0] a, input logic [7:0] v);
      bus(1'b1, OFS_MEM_ADDR, {24'h0, a});
      bus(1'b1, OFS_MEM_DATA, {24'h0, v});
   endtask
   task automatic cm(input logic [7:0] a, input logic [7:0] v);
      bus(1'b1, OFS_MEM_ADDR, {24'h0, a});
      bus(1'b0, OFS_MEM_DATA, 32'h0);
      `CHK("mem", {24'h0, v}, rv)
   endtask
   task automatic ss(input logic [7:0] v);
      bus(1'b1, OFS_FLAGS, {24'h0, v});
   endtask
   task automatic cs(input logic [7:0] v);
      bus(1'b0, OFS_FLAGS, 32'h0);
      `CHK("flags", {24'h0, v}, rv)
   endtask
   task automatic sp(input logic [4:0] lo, input logic [15:0] v);
      sr(lo, v[7:0]);
      sr(lo + 5'h01, v[15:8]);
   endtask
   task automatic cp(input logic [4:0] lo, input logic [15:0] v);
      cr(lo, v[7:0]);
      cr(lo + 5'h01, v[15:8]);
   endtask
   function automatic logic [31:0] mk(input logic [5:0] op,
      input logic [4:0] d, input logic [4:0] r, input logic [2:0] b,
      input logic [7:0] k, input logic [1:0] p);
      mk = {3'h0, p, k, b, r, d, op};
   endfunction
   // Issue one instruction and poll busy with a bound
   task automatic ex(input logic [31:0] ins);
      int n;
      bus(1'b1, OFS_INSTR, ins);
      n = 0;
      do begin
         bus(1'b0, OFS_STATE, 32'h0);
         n++;
      end while (rv[0] !== 1'b0 && n < 20);
      `CHK("busy", 1'b0, rv[0])
   endtask
   task automatic fl(input logic [5:0] op, input logic [2:0] b,
                     input logic [7:0] i, input logic [7:0] e);
      ss(i);
      ex(mk(op, 5'h00, 5'h00, b, 8'h00, 2'h0));
      cs(e);
   endtask

   // ======================================================
   // Scenarios
   task automatic t_flags;
      logic [7:0] m;
      for (int s = 0; s < 8; s++) begin
         m = 8'h01 << s;
         fl(OP_FRAISE, s[2:0], 8'h00, m);
         fl(OP_FDROP, s[2:0], 8'hFF, ~m);
         fl(OP_RAISE + 6'(s), 3'h0, 8'h00, m);
         fl(OP_DROP + 6'(s), 3'h0, 8'hFF, ~m);
      end
   endtask
   task automatic t_bits;
      sr(5'h05, 8'hA5);
      ss(8'hBF);
      ex(mk(OP_B2T, 5'h05, 5'h05, 3'h2, 8'h00, 2'h0));
      cs(8'hFF);
      ex(mk(OP_B2T, 5'h05, 5'h05, 3'h1, 8'h00, 2'h0));
      cs(8'hBF);
      sr(5'h06, 8'hFF);
      ex(mk(OP_T2B, 5'h06, 5'h06, 3'h3, 8'h00, 2'h0));
      cr(5'h06, 8'hF7);
      cs(8'hBF);
   endtask
   task automatic t_moves;
      ss(8'h55);
      sr(5'h07, 8'h3C);
      ex(mk(OP_SWAP, 5'h07, 5'h07, 3'h0, 8'h00, 2'h0));
      cr(5'h07, 8'hC3);
      ex(mk(OP_COPY, 5'h08, 5'h07, 3'h0, 8'h00, 2'h0));
      cr(5'h08, 8'hC3);
      sr(5'h06, 8'h12);
      ex(mk(OP_PCOPY, 5'h0A, 5'h06, 3'h0, 8'h00, 2'h0));
      cp(5'h0A, 16'hC312);
      ex(mk(OP_IMM, 5'h09, 5'h09, 3'h0, 8'h5A, 2'h0));
      cr(5'h09, 8'h5A);
      cs(8'h55);
   endtask
   task automatic t_loads;
      ss(8'hA3);
      sp(X_LO, 16'h00FF);
      sm(8'hFF, 8'h77);
      ex(mk(OP_PRD_INC, 5'h01, 5'h01, 3'h0, 8'h00, PTR_X));
      cr(5'h01, 8'h77);
      cp(X_LO, 16'h0100);
      sp(Z_LO, 16'h0000);
      sm(8'hFF, 8'h99);
      ex(mk(OP_PRD_DEC, 5'h03, 5'h03, 3'h0, 8'h00, PTR_Z));
      cr(5'h03, 8'h99);
      cp(Z_LO, 16'hFFFF);
      sp(Z_LO, 16'h0030);
      sm(8'h6F, 8'h44);
      ex(mk(OP_ORD, 5'h04, 5'h04, 3'h0, 8'h3F, PTR_Z));
      cr(5'h04, 8'h44);
      cp(Z_LO, 16'h0030);
      sm(8'hC8, 8'h66);
      ex(mk(OP_DRD, 5'h05, 5'h05, 3'h0, 8'hC8, 2'h0));
      cr(5'h05, 8'h66);
      cs(8'hA3);
      sp(Y_LO, 16'h0080);
      sm(8'h80, 8'h3E);
      ex(mk(OP_PRD, 5'h02, 5'h02, 3'h0, 8'h00, PTR_Y));
      cr(5'h02, 8'h3E);
      cp(Y_LO, 16'h0080);
   endtask
   task automatic t_stores;
      ss(8'h5C);
      sr(5'h0C, 8'hAB);
      sp(Y_LO, 16'h0040);
      ex(mk(OP_PWR_INC, 5'h0C, 5'h0C, 3'h0, 8'h00, PTR_Y));
      cm(8'h40, 8'hAB);
      cp(Y_LO, 16'h0041);
      sr(5'h0D, 8'hCD);
      sp(X_LO, 16'h0051);
      ex(mk(OP_PWR_DEC, 5'h0D, 5'h0D, 3'h0, 8'h00, PTR_X));
      cm(8'h50, 8'hCD);
      cp(X_LO, 16'h0050);
      cs(8'h5C);
      sp(Y_LO, 16'h0060);
      ex(mk(OP_OWR, 5'h0C, 5'h0C, 3'h0, 8'h02, PTR_Y));
      cm(8'h62, 8'hAB);
      cp(Y_LO, 16'h0060);
      sr(5'h0E, 8'h5D);
      sp(Z_LO, 16'h0090);
      ex(mk(OP_PWR, 5'h0E, 5'h0E, 3'h0, 8'h00, PTR_Z));
      cm(8'h90, 8'h5D);
      cp(Z_LO, 16'h0090);
   endtask
   task automatic t_bus;
      bus(1'b0, 8'h1C, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 32'h0, rv)
      bus(1'b1, OFS_STATE, 32'h1);
      `CHK("state write err", 1'b1, er)
   endtask

   // ======================================================
   // Clock, reset, sequence and timeout
   task automatic wrap_up;
      if (err_total == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_flags;
      t_bits;
      t_moves;
      t_loads;
      t_stores;
      t_bus;
      wrap_up;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         wrap_up;
      end
   end
endmodule // tb_top
